// ---- src/sdcp_core.sv ----
// device-side command decoder: bank state, bursts, refresh, calibration
// assumes a controller driving sampled command pins on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module sdcp_core
  import sdcp_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_resetn,
  input  wire sdcp_pkg::sdcp_ca_t       i_ca,
  input  wire sdcp_pkg::sdcp_wbeat_t    i_wbeat,
  input  wire logic                     i_otf_en,
  input  wire logic                     i_init_done,
  output logic [sdcp_pkg::NUM_BANKS-1:0] o_bank_open,
  output logic                          o_burst_busy,
  output sdcp_pkg::sdcp_acc_t           o_acc,
  output logic                          o_acc_valid,
  output logic                          o_illegal,
  output logic                          o_refresh_busy,
  output logic [sdcp_pkg::ROW_W-1:0]    o_refresh_row,
  output logic                          o_zq_busy,
  output logic                          o_zq_update
);
  import sdcp_pkg::*;

  // decode on the rising edge; cke low blocks all commands
  sdcp_cmd_t cmd;
  always_comb begin
    cmd = SDCP_CMD_NOP;
    if (i_ca.cke && !i_ca.cs_n) begin
      case ({i_ca.ras_n, i_ca.cas_n, i_ca.we_n})
        3'h3:    cmd = SDCP_CMD_ACT;
        3'h5:    cmd = SDCP_CMD_RD;
        3'h4:    cmd = SDCP_CMD_WR;
        3'h2:    cmd = SDCP_CMD_PRE;
        3'h1:    cmd = SDCP_CMD_REF;
        3'h6:    cmd = SDCP_CMD_ZQ;
        3'h7:    cmd = SDCP_CMD_NOP;
        default: cmd = SDCP_CMD_OTHER;
      endcase
    end
  end

  logic [NUM_BANKS-1:0]  open_ff,   nxt_open;
  logic [ROW_W-1:0]      row_ff     [NUM_BANKS];
  logic [ROW_W-1:0]      nxt_row    [NUM_BANKS];
  logic [CNT_W-1:0]      trp_ff     [NUM_BANKS];
  logic [CNT_W-1:0]      nxt_trp    [NUM_BANKS];
  logic                  bact_ff,   nxt_bact;
  logic                  bwe_ff,    nxt_bwe;
  logic                  bap_ff,    nxt_bap;
  logic [BANK_W-1:0]     bbank_ff,  nxt_bbank;
  logic [COL_W-1:0]      bcol_ff,   nxt_bcol;
  logic [3:0]            blen_ff,   nxt_blen;
  logic [3:0]            bcnt_ff,   nxt_bcnt;
  logic [CNT_W-1:0]      rfc_ff,    nxt_rfc;
  logic [ROW_W-1:0]      rrow_ff,   nxt_rrow;
  logic [CNT_W-1:0]      zq_ff,     nxt_zq;
  logic                  zqup_ff,   nxt_zqup;
  logic                  ill_ff,    nxt_ill;
  sdcp_acc_t             acc_ff,    nxt_acc;
  logic                  accv_ff,   nxt_accv;

  logic [BANK_W-1:0] ba;
  logic [3:0]        beat;
  assign ba = i_ca.ba;
  assign beat = bcnt_ff;

  always_comb begin
    nxt_open  = open_ff;
    nxt_row   = row_ff;
    nxt_trp   = trp_ff;
    nxt_bact  = bact_ff;
    nxt_bwe   = bwe_ff;
    nxt_bap   = bap_ff;
    nxt_bbank = bbank_ff;
    nxt_bcol  = bcol_ff;
    nxt_blen  = blen_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_rfc   = rfc_ff;
    nxt_rrow  = rrow_ff;
    nxt_zq    = zq_ff;
    nxt_zqup  = 1'b0;
    nxt_ill   = 1'b0;
    nxt_acc   = acc_ff;
    nxt_accv  = 1'b0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (trp_ff[b] != '0)
        nxt_trp[b] = trp_ff[b] - 1'b1;
    end
    if (rfc_ff != '0)
      nxt_rfc = rfc_ff - 1'b1;
    // calibration engine, then result handoff to the drivers
    if (zq_ff != '0) begin
      nxt_zq = zq_ff - 1'b1;
      if (zq_ff == 1) nxt_zqup = 1'b1;
    end
    // burst in progress always runs out; nothing truncates it
    if (bact_ff) begin
      nxt_acc.we   = bwe_ff;
      nxt_acc.bank = bbank_ff;
      nxt_acc.row  = row_ff[bbank_ff];
      // wrap inside the chop or full burst from the start column
      nxt_acc.col  = {bcol_ff[COL_W-1:3], bcol_ff[2:0] + beat[2:0]};
      if (blen_ff == BURST_CHOP)
        nxt_acc.col[2] = bcol_ff[2];
      nxt_acc.data = i_wbeat.dq;
      // masked beat stores nothing
      nxt_accv = !(bwe_ff && (i_wbeat.dm || !i_wbeat.valid));
      nxt_bcnt = bcnt_ff + 1'b1;
      if (bcnt_ff == blen_ff - 1'b1) begin
        nxt_bact = 1'b0;
        if (bap_ff) begin
          // auto precharge closes the row at burst end
          nxt_open[bbank_ff] = 1'b0;
          nxt_trp[bbank_ff]  = CNT_W'(TRP_CYC);
        end
      end
    end
    if (rfc_ff != '0 && cmd != SDCP_CMD_NOP) begin
      nxt_ill = 1'b1;
    end else begin
      case (cmd)
        SDCP_CMD_ACT: begin
          // second activate or early activate is flagged
          if (open_ff[ba] || trp_ff[ba] != '0) begin
            nxt_ill = 1'b1;
          end else begin
            nxt_open[ba] = 1'b1;
            nxt_row[ba]  = i_ca.addr;
          end
        end
        SDCP_CMD_RD, SDCP_CMD_WR: begin
          // closed bank, or a burst with beats left after this cycle, is refused
          if (!open_ff[ba] || (bact_ff && nxt_bact)) begin
            nxt_ill = 1'b1;
          end else begin
            nxt_bact  = 1'b1;
            nxt_bwe   = (cmd == SDCP_CMD_WR);
            nxt_bap   = i_ca.addr[BIT_AP];
            nxt_bbank = ba;
            nxt_bcol  = i_ca.addr[COL_W-1:0];
            nxt_bcnt  = '0;
            // on-the-fly chop select
            nxt_blen  = (i_otf_en && !i_ca.addr[BIT_BC]) ?
                        BURST_CHOP : BURST_FULL;
          end
        end
        SDCP_CMD_PRE: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            // all banks on bit ten, else only the named bank
            if (i_ca.addr[BIT_AP] || ba == BANK_W'(b)) begin
              nxt_open[b] = 1'b0;
              // idle bank: no-op, timing restarts anyway
              nxt_trp[b]  = CNT_W'(TRP_CYC);
            end
          end
        end
        SDCP_CMD_REF: begin
          if (open_ff != '0) begin
            nxt_ill = 1'b1;
          end else begin
            // internal row counter, address ignored
            nxt_rfc  = CNT_W'(TRFC_CYC);
            nxt_rrow = rrow_ff + 1'b1;
          end
        end
        SDCP_CMD_ZQ: begin
          if (zq_ff == '0) begin
            // long vs short window by bit ten
            if (!i_ca.addr[BIT_AP])
              nxt_zq = CNT_W'(ZQCS_CYCLES);
            else if (i_init_done)
              nxt_zq = CNT_W'(ZQOPER_CYCLES);
            else
              nxt_zq = CNT_W'(ZQINIT_CYCLES);
          end else begin
            nxt_ill = 1'b1;
          end
        end
        SDCP_CMD_OTHER: nxt_ill = 1'b0;
        default:        nxt_ill = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      open_ff  <= '0;
      bact_ff  <= 1'b0;
      bwe_ff   <= 1'b0;
      bap_ff   <= 1'b0;
      bbank_ff <= '0;
      bcol_ff  <= '0;
      blen_ff  <= BURST_FULL;
      bcnt_ff  <= '0;
      rfc_ff   <= '0;
      rrow_ff  <= '0;
      zq_ff    <= '0;
      zqup_ff  <= 1'b0;
      ill_ff   <= 1'b0;
      acc_ff   <= '0;
      accv_ff  <= 1'b0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_ff[b] <= '0;
        trp_ff[b] <= '0;
      end
    end else begin
      open_ff  <= nxt_open;
      bact_ff  <= nxt_bact;
      bwe_ff   <= nxt_bwe;
      bap_ff   <= nxt_bap;
      bbank_ff <= nxt_bbank;
      bcol_ff  <= nxt_bcol;
      blen_ff  <= nxt_blen;
      bcnt_ff  <= nxt_bcnt;
      rfc_ff   <= nxt_rfc;
      rrow_ff  <= nxt_rrow;
      zq_ff    <= nxt_zq;
      zqup_ff  <= nxt_zqup;
      ill_ff   <= nxt_ill;
      acc_ff   <= nxt_acc;
      accv_ff  <= nxt_accv;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_ff[b] <= nxt_row[b];
        trp_ff[b] <= nxt_trp[b];
      end
    end
  end

  assign o_bank_open    = open_ff;
  assign o_burst_busy   = bact_ff;
  assign o_acc          = acc_ff;
  assign o_acc_valid    = accv_ff;
  assign o_illegal      = ill_ff;
  assign o_refresh_busy = (rfc_ff != '0);
  assign o_refresh_row  = rrow_ff;
  assign o_zq_busy      = (zq_ff != '0);
  assign o_zq_update    = zqup_ff;
endmodule
`default_nettype wire

// ---- src/sdcp_pkg.sv ----
// package for the dram command protocol core
// shared by the device-side command decoder; no registers, one clock
package sdcp_pkg;
  localparam int          NUM_BANKS    = 8;
  localparam int          BANK_W       = 3;
  localparam int          ROW_W        = 15;
  localparam int          COL_W        = 10;
  localparam int          DQ_W         = 8;
  localparam int          BEAT_W       = 3;
  localparam int          BIT_AP       = 10;
  localparam int          BIT_BC       = 12;
  localparam int          CLK_PERIOD_NS = 8;
  // calibration windows in clock cycles
  localparam int          ZQCS_CYCLES  = 64;
  localparam int          ZQINIT_CYCLES = 512;
  localparam int          ZQOPER_CYCLES = 256;
  // core timing windows in ns, converted to cycles rounded up
  localparam int          TRP_NS       = 15;
  localparam int          TRFC_NS      = 160;
  localparam int          TRP_CYC      = (TRP_NS + CLK_PERIOD_NS - 1) /
                                         CLK_PERIOD_NS;
  localparam int          TRFC_CYC     = (TRFC_NS + CLK_PERIOD_NS - 1) /
                                         CLK_PERIOD_NS;
  localparam int          CNT_W        = 10;
  localparam logic [3:0]  BURST_FULL   = 4'h8;
  localparam logic [3:0]  BURST_CHOP   = 4'h4;

  typedef enum logic [2:0] {
    SDCP_CMD_NOP, SDCP_CMD_ACT, SDCP_CMD_RD, SDCP_CMD_WR,
    SDCP_CMD_PRE, SDCP_CMD_REF, SDCP_CMD_ZQ, SDCP_CMD_OTHER
  } sdcp_cmd_t;

  // pins sampled at the rising clock edge
  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0]  addr;
  } sdcp_ca_t;

  // write data beat with its mask
  typedef struct packed {
    logic            valid;
    logic            dm;
    logic [DQ_W-1:0] dq;
  } sdcp_wbeat_t;

  // one array access issued to storage
  typedef struct packed {
    logic              we;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [DQ_W-1:0]   data;
  } sdcp_acc_t;
endpackage

// ---- verif/sdcp_core_sva.sv ----
// assertions on the command decoder ports
// bound to every sdcp_core instance, single clock domain
`timescale 1ns/10ps
`default_nettype none
module sdcp_core_sva
  import sdcp_pkg::*;
(
  input wire logic                   i_clk_sys,
  input wire logic                   i_resetn,
  input wire sdcp_pkg::sdcp_ca_t     i_ca,
  input wire sdcp_pkg::sdcp_wbeat_t  i_wbeat,
  input wire logic                   i_otf_en,
  input wire logic [NUM_BANKS-1:0]   o_bank_open,
  input wire logic                   o_burst_busy,
  input wire sdcp_pkg::sdcp_acc_t    o_acc,
  input wire logic                   o_acc_valid,
  input wire logic                   o_illegal,
  input wire logic                   o_refresh_busy,
  input wire logic                   o_zq_busy,
  input wire logic                   o_zq_update
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic       cmd;
  logic       idle;
  logic [2:0] op;
  assign cmd  = i_ca.cke && !i_ca.cs_n;
  assign op   = {i_ca.ras_n, i_ca.cas_n, i_ca.we_n};
  assign idle = cmd && !o_refresh_busy;

  chk_act_open:
    assert property (idle && op == 3'h3 && !o_bank_open[i_ca.ba]
      |=> o_bank_open[$past(i_ca.ba)] || o_illegal) else $error("act no open");
  chk_rd_closed:
    assert property (cmd && op[2:1] == 2'h2 && !o_bank_open[i_ca.ba]
      |=> o_illegal) else $error("idle bank access taken");
  chk_pre_all:
    assert property (idle && op == 3'h2 && i_ca.addr[10]
      |=> o_bank_open == '0) else $error("precharge all left bank open");
  chk_ref_len:
    assert property (idle && op == 3'h1 && o_bank_open == '0
      |=> o_refresh_busy [*8]) else $error("refresh period cut short");
  chk_ref_block:
    assert property (cmd && op != 3'h7 && o_refresh_busy |=> o_illegal)
    else $error("command during refresh taken");
  chk_zqs_time:
    assert property (idle && op == 3'h6 && !i_ca.addr[10] && !o_zq_busy
      |-> ##65 o_zq_update) else $error("short calibration late");
  chk_rd_burst:
    assert property (idle && op == 3'h5 && o_bank_open[i_ca.ba] &&
      !o_burst_busy && (!i_otf_en || i_ca.addr[12])
      |-> ##2 o_acc_valid [*8]) else $error("read burst truncated");
  chk_mask_drop:
    assert property (o_acc_valid && o_acc.we
      |-> $past(i_wbeat.valid) && !$past(i_wbeat.dm))
    else $error("masked beat written");

  cov_zq:  cover property (o_zq_update);
  cov_wr:  cover property (o_acc_valid && o_acc.we);
  cov_ill: cover property (o_illegal);
endmodule

bind sdcp_core sdcp_core_sva u_sva (.*);
`default_nettype wire

// ---- verif/sdcp_core_tb_top.sv ----
// top bench for the command decoder with a controller model
// one 125 MHz clock; scenarios run in sequence
`timescale 1ns/10ps
`default_nettype none
module sdcp_core_tb_top;
  import sdcp_pkg::*;
  logic        i_clk_sys = 1'b0, i_resetn = 1'b0;
  logic        i_otf_en = 1'b0, i_init_done = 1'b0;
  sdcp_ca_t    i_ca;
  sdcp_wbeat_t i_wbeat;
  sdcp_acc_t   o_acc;
  logic [7:0]  o_bank_open;
  logic [14:0] o_refresh_row;
  logic        o_burst_busy, o_acc_valid, o_illegal;
  logic        o_refresh_busy, o_zq_busy, o_zq_update;
  int          fail_count = 0, comparisons = 0, ill_n = 0, rb_n = 0;
  int          bb_n = 0, zb_n = 0;
  sdcp_acc_t   q[$];

  sdcp_ctrl_model ctrl (.i_clk_sys, .o_ca(i_ca), .o_wbeat(i_wbeat));
  sdcp_core uut (.i_clk_sys, .i_resetn, .i_ca, .i_wbeat, .i_otf_en,
    .i_init_done, .o_bank_open, .o_burst_busy, .o_acc, .o_acc_valid,
    .o_illegal, .o_refresh_busy, .o_refresh_row, .o_zq_busy, .o_zq_update);

  initial forever #4 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) begin
    if (o_acc_valid) q.push_back(o_acc);
    if (o_illegal) ill_n++;
    if (o_refresh_busy) rb_n++;
    if (o_burst_busy) bb_n++;
    if (o_zq_busy) zb_n++;
  end

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic s_zq();
    int n, e;
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk_sys);
      i_init_done <= (i == 2);
      e = (i == 0) ? ZQCS_CYCLES : (i == 1) ? ZQINIT_CYCLES : ZQOPER_CYCLES;
      zb_n = 0;
      ctrl.cmd(3'h6, 3'h0, {4'h0, i > 0, 10'h0}, 8'h0, 0);
      n = 0;
      do begin
        @(negedge i_clk_sys);
        n++;
      end while (!o_zq_update && n < 600);
      cmp("zq time", e + 1, n);
      cmp("zq busy", e, zb_n);
      if (!o_zq_update) conclude();
    end
  endtask
  task automatic s_read();
    ctrl.cmd(3'h3, 3'h3, 15'h1234, 8'h0, 3);
    @(negedge i_clk_sys);
    cmp("bank open", 8'h08, o_bank_open);
    q.delete();
    bb_n = 0;
    ctrl.cmd(3'h5, 3'h3, 15'h0005, 8'h0, 11);
    cmp("read beats", 8, q.size());
    cmp("busy span", BURST_FULL, bb_n);
    cmp("read row", {15'h1234, 3'h3}, {q[0].row, q[0].bank});
    foreach (q[k]) cmp("read col", (k + 5) % 8, q[k].col);
  endtask
  task automatic s_write();
    int b[3] = '{0, 2, 3};
    @(posedge i_clk_sys);
    i_otf_en <= 1'b1;
    q.delete();
    ctrl.cmd(3'h4, 3'h3, 15'h0402, 8'h02, 11);
    cmp("chop beats", 3, q.size());
    foreach (q[k]) begin
      cmp("wr col", (b[k] + 2) % 4, q[k].col);
      cmp("wr data", 9'h1A0 + b[k], {q[k].we, q[k].data});
    end
    @(negedge i_clk_sys);
    cmp("ap close", 8'h00, o_bank_open);
  endtask
  task automatic s_bank();
    int n0 = ill_n;
    ctrl.cmd(3'h5, 3'h3, 15'h0, 8'h0, 3);
    ctrl.cmd(3'h3, 3'h1, 15'h0, 8'h0, 3);
    ctrl.cmd(3'h3, 3'h1, 15'h7, 8'h0, 3);
    ctrl.cmd(3'h3, 3'h6, 15'h0, 8'h0, 3);
    ctrl.cmd(3'h2, 3'h1, 15'h0, 8'h0, 3);
    @(negedge i_clk_sys);
    cmp("one bank", 8'h40, o_bank_open);
    cmp("refusals", n0 + 2, ill_n);
    ctrl.cmd(3'h2, 3'h1, 15'h0, 8'h0, 3);
    ctrl.cmd(3'h2, 3'h2, 15'h0400, 8'h0, 3);
    @(negedge i_clk_sys);
    cmp("all closed", 8'h00, o_bank_open);
    cmp("idle pre", n0 + 2, ill_n);
    ctrl.cmd(3'h2, 3'h4, 15'h0, 8'h0, 0);
    ctrl.cmd(3'h3, 3'h4, 15'h0, 8'h0, 3);
    @(negedge i_clk_sys);
    cmp("pre restart", n0 + 3, ill_n);
  endtask
  task automatic s_ref();
    logic [14:0] r0 = o_refresh_row;
    int n0 = ill_n;
    rb_n = 0;
    ctrl.cmd(3'h1, 3'h0, 15'h0, 8'h0, 3);
    ctrl.cmd(3'h3, 3'h0, 15'h0, 8'h0, 25);
    @(negedge i_clk_sys);
    cmp("refresh span", TRFC_CYC, rb_n);
    cmp("blocked act", n0 + 1, ill_n);
    cmp("act refused", 8'h00, o_bank_open);
    cmp("row moved", 15'(r0 + 1'b1), o_refresh_row);
  endtask
  task automatic s_conc();
    int n0 = ill_n;
    ctrl.cmd(3'h3, 3'h2, 15'h0, 8'h0, 1);
    ctrl.cmd(3'h3, 3'h5, 15'h0, 8'h0, 1);
    q.delete();
    // read lands on the edge where the auto-precharged write ends
    ctrl.cmd(3'h4, 3'h2, 15'h1400, 8'h0, 6);
    ctrl.cmd(3'h5, 3'h5, 15'h1000, 8'h0, 11);
    @(negedge i_clk_sys);
    cmp("conc beats", 16, q.size());
    cmp("conc rd bank", {1'b0, 3'h5}, {q[8].we, q[8].bank});
    cmp("conc refusals", n0, ill_n);
    cmp("conc banks", 8'h20, o_bank_open);
  endtask

  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    s_zq();
    s_read();
    s_write();
    s_bank();
    s_ref();
    s_conc();
    conclude();
  end
endmodule
`default_nettype wire

// ---- verif/sdcp_ctrl_model.sv ----
// controller model driving command pins and write beats
// each call waits a rising edge, then launches one command
`timescale 1ns/10ps
`default_nettype none
module sdcp_ctrl_model
  import sdcp_pkg::*;
(
  input  wire logic             i_clk_sys,
  output sdcp_pkg::sdcp_ca_t    o_ca,
  output sdcp_pkg::sdcp_wbeat_t o_wbeat
);
  initial begin
    o_ca    = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0};
    o_wbeat = '0;
  end
  // gap plus one nop cycles follow; callers open a bank before access and keep
  // precharge and refresh spacing unless refusal is wanted
  // a lone refresh per run stays inside rate and posting limits
  task automatic cmd(input logic [2:0] op, input logic [2:0] ba,
                     input logic [14:0] a, input logic [7:0] dm,
                     input int gap);
    @(posedge i_clk_sys);
    o_ca <= '{1'b1, 1'b0, op[2], op[1], op[0], ba, a};
    for (int k = 0; k <= gap; k++) begin
      @(posedge i_clk_sys);
      // address not held after the command
      o_ca    <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, ~ba, ~a};
      o_wbeat <= (op == 3'h4 && k < 8) ? {1'b1, dm[k], 8'hA0 + 8'(k)}
                                       : {1'b0, 1'b0, ~o_wbeat.dq};
    end
  endtask
endmodule
`default_nettype wire
